//--- bench/rtt_pin_model.sv
// external pin source: count clock or trigger pulses
`timescale 1ns/10ps
module rtt_pin_model
(
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [7:0] half_i,
    output logic pin_o
);
    int k = 0;
    initial pin_o = 1'h0;
    // idles low between bursts; edges land off the clock edge, like a real pin
    always @(posedge clk_i)
    begin
        k <= (go_i && k + 1 < half_i) ? k + 1 : 0;
        if (!go_i)
            pin_o <= #7 1'h0;
        else if (k + 1 >= half_i)
            pin_o <= #7 ~pin_o;
    end
endmodule // rtt_pin_model

//--- bench/rtt_reload_timers_assertions.sv
// port-level checker for the reload timers
`timescale 1ns/10ps
module rtt_reload_timers_chk
(
    input wire CLK_I,
    input wire ARST_N_I,
    input wire [2:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire [7:0] RDATA_O,
    input wire TIMER_THREE_IRQ_ENABLE_I,
    input wire TIMER_FOUR_IRQ_ENABLE_I,
    input wire TIMER_THREE_IRQ_O,
    input wire TIMER_FOUR_IRQ_O,
    input wire TIMER_FOUR_PIN_OE_N_O,
    input wire BAUD_TICK_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);
    // modes 00/01 with compare bit: pin must be driven
    sequence s_cmp_wr;
        WR_I && ADDR_I == 3'h3 && WDATA_I[6] && !WDATA_I[3];
    endsequence
    sequence s_edge_wr;
        WR_I && ADDR_I == 3'h3 && WDATA_I[3] ##1 !(WR_I && ADDR_I == 3'h3);
    endsequence
    chk_rd_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data not zero outside a reply");
    chk_unmapped_zero: assert property (RD_I && ADDR_I == 3'h7 |=> RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    chk_irq3_gate: assert property (TIMER_THREE_IRQ_O |-> $past(TIMER_THREE_IRQ_ENABLE_I))
        else $error("timer three irq without enable");
    chk_irq4_gate: assert property (TIMER_FOUR_IRQ_O |-> $past(TIMER_FOUR_IRQ_ENABLE_I))
        else $error("timer four irq without enable");
    chk_irq3_hold: assert property (TIMER_THREE_IRQ_O && TIMER_THREE_IRQ_ENABLE_I
        && !$past(WR_I && ADDR_I == 3'h0) |=> TIMER_THREE_IRQ_O)
        else $error("timer three flag dropped without a write");
    chk_irq4_hold: assert property (TIMER_FOUR_IRQ_O && TIMER_FOUR_IRQ_ENABLE_I
        && !$past(WR_I && ADDR_I == 3'h3) |=> TIMER_FOUR_IRQ_O)
        else $error("timer four flag dropped without a write");
    chk_oe_compare: assert property (s_cmp_wr |-> ##[1:2] !TIMER_FOUR_PIN_OE_N_O)
        else $error("compare pin not driven");
    chk_oe_edge_mode: assert property (s_edge_wr |=> TIMER_FOUR_PIN_OE_N_O)
        else $error("pin driven in an edge mode");
    chk_tick_single: assert property (BAUD_TICK_O |=> !BAUD_TICK_O [*8])
        else $error("baud tick too close");
endmodule // rtt_reload_timers_chk
bind rtt_reload_timers rtt_reload_timers_chk rtt_reload_timers_chk_inst (
    .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .TIMER_THREE_IRQ_ENABLE_I(TIMER_THREE_IRQ_ENABLE_I),
    .TIMER_FOUR_IRQ_ENABLE_I(TIMER_FOUR_IRQ_ENABLE_I),
    .TIMER_THREE_IRQ_O(TIMER_THREE_IRQ_O), .TIMER_FOUR_IRQ_O(TIMER_FOUR_IRQ_O),
    .TIMER_FOUR_PIN_OE_N_O(TIMER_FOUR_PIN_OE_N_O), .BAUD_TICK_O(BAUD_TICK_O));

//--- bench/rtt_reload_timers_tb.sv
// self-checking bench for the reload timers
`timescale 1ns/10ps
module rtt_reload_timers_tb;
    logic clk = 1'h0, arst_n = 1'h0, wr = 1'h0, rd = 1'h0, pd = 1'h0;
    logic en3 = 1'h0, en4 = 1'h0, go3 = 1'h0, go4 = 1'h0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, half4 = 8'h04, rdata;
    logic irq3, irq4, pin4, oe4_n, tick, p3, p4;
    int bad_count = 0, tests_run = 0, cyc = 0, t, p, k, n;
    int dv[4] = '{1, 8, 64, 256};
    always #50 clk = ~clk;
    rtt_reload_timers rtt_reload_timers_inst (.CLK_I(clk), .ARST_N_I(arst_n),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .POWERDOWN_I(pd), .TIMER_THREE_PIN_I(p3), .TIMER_FOUR_PIN_I(p4),
        .TIMER_THREE_IRQ_ENABLE_I(en3), .TIMER_FOUR_IRQ_ENABLE_I(en4),
        .TIMER_THREE_IRQ_O(irq3), .TIMER_FOUR_IRQ_O(irq4),
        .TIMER_FOUR_PIN_O(pin4), .TIMER_FOUR_PIN_OE_N_O(oe4_n),
        .BAUD_TICK_O(tick));
    rtt_pin_model pin3_inst (.clk_i(clk), .go_i(go3), .half_i(8'h04), .pin_o(p3));
    rtt_pin_model pin4_inst (.clk_i(clk), .go_i(go4), .half_i(half4), .pin_o(p4));
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            tally_and_finish;
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %0t got %0h want %0h", $time, g, e);
        end
    endtask
    // one idle cycle before each access keeps strobes single-driven
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] m,
                          input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 chk(rdata & m, e);
    endtask
    task automatic ld(input int tm, input logic [15:0] v);
        wr_reg(tm ? 3'h5 : 3'h2, v[15:8]);
        wr_reg(tm ? 3'h4 : 3'h1, v[7:0]);
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        arst_n <= 1'h1;
        repeat (3) @(posedge clk);
        for (k = 0; k < 8; k++)
            rd_chk(k[2:0], 8'hff, 8'h00);
        wr_reg(3'h7, 8'hff);
        rd_chk(3'h7, 8'hff, 8'h00);
        wr_reg(3'h0, 8'h7b);
        rd_chk(3'h0, 8'hff, 8'h73);
        ld(0, 16'h1234);
        rd_chk(3'h2, 8'hff, 8'h12);
        rd_chk(3'h1, 8'hff, 8'h34);
        ld(1, 16'habcd);
        rd_chk(3'h5, 8'hff, 8'hab);
        rd_chk(3'h4, 8'hff, 8'hcd);
        en3 <= 1'h1;
        en4 <= 1'h1;
        ld(0, 16'hfff0);
        wr_reg(3'h0, 8'h04);
        ld(0, 16'h0000);
        rd_chk(3'h2, 8'hff, 8'hff);
        repeat (30) @(posedge clk);
        rd_chk(3'h2, 8'hff, 8'h00);
        wr_reg(3'h0, 8'h84);
        rd_chk(3'h0, 8'h80, 8'h80);
        chk(8'(irq3), 8'h01);
        wr_reg(3'h0, 8'h00);
        rd_chk(3'h0, 8'h80, 8'h00);
        for (t = 0; t < 2; t++)
            for (p = 0; p < 4; p++)
            begin
                ld(t, 16'hfff0);
                wr_reg(t ? 3'h3 : 3'h0, t ? {2'h0, p[1:0], 4'h2}
                       : {2'h0, p[1:0], 2'h1, (p == 3 ? 2'h3 : 2'h0)});
                repeat (8 * dv[p]) @(posedge clk);
                rd_chk(t ? 3'h3 : 3'h0, 8'h80, 8'h00);
                repeat (12 * dv[p] + 4) @(posedge clk);
                rd_chk(t ? 3'h3 : 3'h0, 8'h80, 8'h80);
                wr_reg(t ? 3'h3 : 3'h0, 8'h00);
            end
        pd <= 1'h1;
        go3 <= 1'h1;
        go4 <= 1'h1;
        ld(0, 16'hfff0);
        ld(1, 16'hfff0);
        wr_reg(3'h0, 8'h45);
        wr_reg(3'h3, 8'h03);
        repeat (200) @(posedge clk);
        rd_chk(3'h0, 8'h80, 8'h80);
        rd_chk(3'h3, 8'h80, 8'h80);
        wr_reg(3'h3, 8'h00);
        wr_reg(3'h0, 8'h00);
        ld(0, 16'hfff0);
        wr_reg(3'h0, 8'h44);
        repeat (40) @(posedge clk);
        rd_chk(3'h0, 8'h80, 8'h00);
        wr_reg(3'h0, 8'h00);
        pd <= 1'h0;
        go3 <= 1'h0;
        go4 <= 1'h0;
        ld(1, 16'hfff0);
        wr_reg(3'h3, 8'h42);
        n = 0;
        while (pin4 !== 1'h1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
        chk(8'(pin4), 8'h01);
        chk(8'(oe4_n), 8'h00);
        chk(8'(irq4), 8'h01);
        wr_reg(3'h3, 8'h00);
        ld(1, 16'hffff);
        wr_reg(3'h3, 8'h46);
        n = 0;
        p = 0;
        t = int'(pin4);
        for (k = 0; k < 160; k++)
        begin
            @(negedge clk);
            n += int'(tick);
            if (int'(pin4) != t)
            begin
                p++;
                t = int'(pin4);
            end
        end
        chk(8'(n >= 9 && n <= 11), 8'h01);
        chk(8'(p >= 9 && p <= 11), 8'h01);
        wr_reg(3'h3, 8'h00);
        half4 <= 8'h0a;
        for (k = 0; k < 4; k++)
        begin
            ld(1, 16'hffe0);
            wr_reg(3'h3, {1'h0, k[0], 2'h0, 1'h1, k[1], 2'h2});
            repeat (50) @(posedge clk);
            rd_chk(3'h3, 8'h80, 8'h00);
            go4 <= 1'h1;
            repeat (150) @(posedge clk);
            go4 <= 1'h0;
            rd_chk(3'h3, 8'h80, k[0] ? 8'h00 : 8'h80);
            wr_reg(3'h3, 8'h00);
        end
        tally_and_finish;
    end
endmodule // rtt_reload_timers_tb

//--- verilog/rtt_defines.vh
// register map, field positions, reset values and counts for the reload timers
`ifndef RTT_DEFINES_VH
`define RTT_DEFINES_VH
`define RTT_ADDR_W 3
`define RTT_OFF_T3_CTRL 3'h0
`define RTT_OFF_T3_LOW 3'h1
`define RTT_OFF_T3_HIGH 3'h2
`define RTT_OFF_T4_CTRL 3'h3
`define RTT_OFF_T4_LOW 3'h4
`define RTT_OFF_T4_HIGH 3'h5
`define RTT_OFF_MISC 3'h6
`define RTT_T3_FLAG_BIT 7
`define RTT_T3_PDEN_BIT 6
`define RTT_T3_PS_HI 5
`define RTT_T3_PS_LO 4
`define RTT_T3_RUN_BIT 2
`define RTT_T3_CLK_HI 1
`define RTT_T3_CLK_LO 0
`define RTT_T4_FLAG_BIT 7
`define RTT_T4_TC_BIT 6
`define RTT_T4_PS_HI 5
`define RTT_T4_PS_LO 4
`define RTT_T4_MODE_HI 3
`define RTT_T4_MODE_LO 2
`define RTT_T4_RUN_BIT 1
`define RTT_T4_CLKS_BIT 0
`define RTT_T3_CTRL_RESET 8'h00
`define RTT_T4_CTRL_RESET 8'h00
`define RTT_DATA_RESET 16'h0000
`define RTT_T3_CTRL_WMASK 8'hf7
`define RTT_CLK_SYS 2'h0
`define RTT_CLK_PIN 2'h1
`define RTT_MODE_RELOAD 2'h0
`define RTT_MODE_BAUD 2'h1
`define RTT_MODE_RISE 2'h2
`define RTT_MODE_FALL 2'h3
`define RTT_PS_DIV8 8'h07
`define RTT_PS_DIV64 8'h3f
`define RTT_PS_DIV256 8'hff
`define RTT_BAUD_DIV 4'hf
`endif

//--- verilog/rtt_reload_timers.v
// two 16-bit auto-reload timers (three and four) with register port
`timescale 1ns/10ps
`include "rtt_defines.vh"

module rtt_reload_timers
(
    input wire CLK_I,
    input wire ARST_N_I,
    input wire [2:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [7:0] RDATA_O,
    input wire POWERDOWN_I,
    input wire TIMER_THREE_PIN_I,
    input wire TIMER_FOUR_PIN_I,
    input wire TIMER_THREE_IRQ_ENABLE_I,
    input wire TIMER_FOUR_IRQ_ENABLE_I,
    output reg TIMER_THREE_IRQ_O,
    output reg TIMER_FOUR_IRQ_O,
    output reg TIMER_FOUR_PIN_O,
    output reg TIMER_FOUR_PIN_OE_N_O,
    output reg BAUD_TICK_O
);

    // prescaler terminal mask for a two-bit ratio code
    function [7:0] ps_mask;
        input [1:0] code;
        begin
            case (code)
                2'h0: ps_mask = 8'h00;
                2'h1: ps_mask = `RTT_PS_DIV8;
                2'h2: ps_mask = `RTT_PS_DIV64;
                default: ps_mask = `RTT_PS_DIV256;
            endcase
        end
    endfunction

    // prescaler has reached the terminal value of the chosen ratio
    function ps_hit;
        input [7:0] count;
        input [7:0] mask;
        begin
            ps_hit = ((count & mask) == mask);
        end
    endfunction

    // write strobe aimed at one register offset
    function reg_hit;
        input strobe;
        input [2:0] addr;
        input [2:0] offset;
        begin
            reg_hit = strobe & (addr == offset);
        end
    endfunction

    // overflow flag: a hardware set wins over a software write of zero
    function flag_next;
        input flag;
        input set;
        input wr;
        input wbit;
        begin
            if (set)
                flag_next = 1'b1;
            else if (wr)
                flag_next = flag & wbit;
            else
                flag_next = flag;
        end
    endfunction

    reg rst_meta_q;
    reg rst_sync_q;
    wire rst_n;
    reg p3_meta_q;
    reg p3_sync_q;
    reg p3_prev_q;
    reg p4_meta_q;
    reg p4_sync_q;
    reg p4_prev_q;
    reg pd_meta_q;
    reg pd_sync_q;

    always @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    // pins are asynchronous; the first stage is never looked at
    always @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            p3_meta_q <= 1'b0;
            p3_sync_q <= 1'b0;
            p3_prev_q <= 1'b0;
            p4_meta_q <= 1'b0;
            p4_sync_q <= 1'b0;
            p4_prev_q <= 1'b0;
            pd_meta_q <= 1'b0;
            pd_sync_q <= 1'b0;
        end
        else
        begin
            p3_meta_q <= TIMER_THREE_PIN_I;
            p3_sync_q <= p3_meta_q;
            p3_prev_q <= p3_sync_q;
            p4_meta_q <= TIMER_FOUR_PIN_I;
            p4_sync_q <= p4_meta_q;
            p4_prev_q <= p4_sync_q;
            pd_meta_q <= POWERDOWN_I;
            pd_sync_q <= pd_meta_q;
        end
    end

    wire p3_rise = p3_sync_q & ~p3_prev_q;
    wire p4_rise = p4_sync_q & ~p4_prev_q;
    wire p4_fall = ~p4_sync_q & p4_prev_q;

    // timer three state
    reg [7:0] t3_ctrl_q;
    reg [15:0] t3_cnt_q;
    reg [15:0] t3_rld_q;
    reg [7:0] t3_hbuf_q;
    reg [7:0] t3_ps_q;
    // timer four state
    reg [7:0] t4_ctrl_q;
    reg [15:0] t4_cnt_q;
    reg [15:0] t4_rld_q;
    reg [7:0] t4_hbuf_q;
    reg [7:0] t4_ps_q;
    reg t4_armed_q;
    reg [3:0] baud_q;
    reg [15:0] t3_cnt_d;
    reg [7:0] t3_ps_d;
    reg [15:0] t4_cnt_d;
    reg [7:0] t4_ps_d;

    wire t3_run = t3_ctrl_q[`RTT_T3_RUN_BIT];
    wire [1:0] t3_clks = t3_ctrl_q[`RTT_T3_CLK_HI:`RTT_T3_CLK_LO];
    wire t3_pin_clk = (t3_clks == `RTT_CLK_PIN);
    wire [7:0] t3_mask = ps_mask(t3_ctrl_q[`RTT_T3_PS_HI:`RTT_T3_PS_LO]);
    wire t3_src_ok = (t3_clks != 2'h2);
    wire t3_alive = ~pd_sync_q |
        (t3_ctrl_q[`RTT_T3_PDEN_BIT] & t3_pin_clk);
    wire t3_src = t3_pin_clk ? p3_rise : 1'b1;
    wire t3_go = t3_run & t3_src_ok & t3_alive & t3_src;
    wire t3_tick = t3_go & ps_hit(t3_ps_q, t3_mask);
    wire t3_ovf = t3_tick & (t3_cnt_q == 16'hffff);

    wire t4_run = t4_ctrl_q[`RTT_T4_RUN_BIT];
    wire t4_tc = t4_ctrl_q[`RTT_T4_TC_BIT];
    wire [1:0] t4_mode = t4_ctrl_q[`RTT_T4_MODE_HI:`RTT_T4_MODE_LO];
    wire t4_edge_mode = t4_mode[1];
    // edge modes ignore the clock select bit
    wire t4_pin_clk = t4_ctrl_q[`RTT_T4_CLKS_BIT] & ~t4_edge_mode;
    wire [7:0] t4_mask = ps_mask(t4_ctrl_q[`RTT_T4_PS_HI:`RTT_T4_PS_LO]);
    wire t4_trig = (t4_mode == `RTT_MODE_RISE) ? p4_rise : p4_fall;
    wire t4_src = t4_pin_clk ? p4_rise : 1'b1;
    wire t4_counting = t4_run & (~t4_edge_mode | t4_armed_q);
    wire t4_retrig = t4_run & t4_edge_mode & t4_armed_q & t4_tc &
        t4_trig;
    wire t4_tick = t4_counting & t4_src &
        ps_hit(t4_ps_q, t4_mask);
    wire t4_ovf = t4_tick & (t4_cnt_q == 16'hffff) & ~t4_retrig;

    wire wr_t3c = reg_hit(WR_I, ADDR_I, `RTT_OFF_T3_CTRL);
    wire wr_t3l = reg_hit(WR_I, ADDR_I, `RTT_OFF_T3_LOW);
    wire wr_t3h = reg_hit(WR_I, ADDR_I, `RTT_OFF_T3_HIGH);
    wire wr_t4c = reg_hit(WR_I, ADDR_I, `RTT_OFF_T4_CTRL);
    wire wr_t4l = reg_hit(WR_I, ADDR_I, `RTT_OFF_T4_LOW);
    wire wr_t4h = reg_hit(WR_I, ADDR_I, `RTT_OFF_T4_HIGH);

    // prescalers restart whenever their timer is stopped
    always @*
    begin
        t3_ps_d = t3_ps_q;
        if (!t3_run)
            t3_ps_d = 8'h00;
        else if (t3_go)
            t3_ps_d = t3_ps_q + 8'h01;
    end

    // restart on a retrigger too, so the period is exact
    always @*
    begin
        t4_ps_d = t4_ps_q;
        if (!t4_counting || t4_retrig)
            t4_ps_d = 8'h00;
        else if (t4_src)
            t4_ps_d = t4_ps_q + 8'h01;
    end

    // next count: a stopped low-byte write wins over counting
    always @*
    begin
        t3_cnt_d = t3_cnt_q;
        if (wr_t3l && !t3_run)
            t3_cnt_d = {t3_hbuf_q, WDATA_I};
        else if (t3_ovf)
            t3_cnt_d = t3_rld_q;
        else if (t3_tick)
            t3_cnt_d = t3_cnt_q + 16'h0001;
    end

    // run bit alone never clears the count
    always @*
    begin
        t4_cnt_d = t4_cnt_q;
        if (wr_t4l && !t4_run)
            t4_cnt_d = {t4_hbuf_q, WDATA_I};
        else if (t4_ovf || t4_retrig)
            t4_cnt_d = t4_rld_q;
        else if (t4_tick)
            t4_cnt_d = t4_cnt_q + 16'h0001;
    end

    // timer three
    always @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            t3_ctrl_q <= `RTT_T3_CTRL_RESET;
            t3_cnt_q <= `RTT_DATA_RESET;
            t3_rld_q <= `RTT_DATA_RESET;
            t3_hbuf_q <= 8'h00;
            t3_ps_q <= 8'h00;
        end
        else
        begin
            if (wr_t3c)
                t3_ctrl_q <= WDATA_I & `RTT_T3_CTRL_WMASK;
            // flag: written zero clears, overflow sets and wins
            t3_ctrl_q[`RTT_T3_FLAG_BIT] <= flag_next(
                t3_ctrl_q[`RTT_T3_FLAG_BIT], t3_ovf, wr_t3c,
                WDATA_I[`RTT_T3_FLAG_BIT]);
            t3_ps_q <= t3_ps_d;
            // high byte waits in a buffer until the low byte commits
            if (wr_t3h)
                t3_hbuf_q <= WDATA_I;
            if (wr_t3l)
                t3_rld_q <= {t3_hbuf_q, WDATA_I};
            t3_cnt_q <= t3_cnt_d;
        end
    end

    // timer four
    always @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            t4_ctrl_q <= `RTT_T4_CTRL_RESET;
            t4_cnt_q <= `RTT_DATA_RESET;
            t4_rld_q <= `RTT_DATA_RESET;
            t4_hbuf_q <= 8'h00;
            t4_ps_q <= 8'h00;
            t4_armed_q <= 1'b0;
            baud_q <= 4'h0;
        end
        else
        begin
            if (wr_t4c)
                t4_ctrl_q <= WDATA_I;
            t4_ctrl_q[`RTT_T4_FLAG_BIT] <= flag_next(
                t4_ctrl_q[`RTT_T4_FLAG_BIT], t4_ovf, wr_t4c,
                WDATA_I[`RTT_T4_FLAG_BIT]);
            t4_ps_q <= t4_ps_d;
            // arming: wait for an edge, disarm on overflow
            if (!t4_run || !t4_edge_mode)
                t4_armed_q <= 1'b0;
            else if (t4_ovf)
                t4_armed_q <= 1'b0;
            else if (!t4_armed_q && t4_trig)
                t4_armed_q <= 1'b1;
            if (wr_t4h)
                t4_hbuf_q <= WDATA_I;
            if (wr_t4l)
                t4_rld_q <= {t4_hbuf_q, WDATA_I};
            t4_cnt_q <= t4_cnt_d;
            // baud sixteenth divider counts overflows in baud mode
            if (t4_mode != `RTT_MODE_BAUD)
                baud_q <= 4'h0;
            else if (t4_ovf)
                baud_q <= baud_q + 4'h1;
        end
    end

    // compare pin toggles only on the system clock
    always @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            TIMER_FOUR_PIN_O <= 1'b0;
        else if (t4_tc && !t4_pin_clk && !t4_edge_mode && t4_ovf)
        begin
            if (t4_mode == `RTT_MODE_RELOAD)
                TIMER_FOUR_PIN_O <= ~TIMER_FOUR_PIN_O;
            else if (baud_q == `RTT_BAUD_DIV)
                TIMER_FOUR_PIN_O <= ~TIMER_FOUR_PIN_O;
        end
    end

    // outputs and register reads
    always @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            RDATA_O <= 8'h00;
            TIMER_THREE_IRQ_O <= 1'b0;
            TIMER_FOUR_IRQ_O <= 1'b0;
            TIMER_FOUR_PIN_OE_N_O <= 1'b1;
            BAUD_TICK_O <= 1'b0;
        end
        else
        begin
            TIMER_THREE_IRQ_O <= t3_ctrl_q[`RTT_T3_FLAG_BIT] &
                TIMER_THREE_IRQ_ENABLE_I;
            TIMER_FOUR_IRQ_O <= t4_ctrl_q[`RTT_T4_FLAG_BIT] &
                TIMER_FOUR_IRQ_ENABLE_I;
            TIMER_FOUR_PIN_OE_N_O <= ~(t4_tc & ~t4_edge_mode);
            BAUD_TICK_O <= t4_ovf & (baud_q == `RTT_BAUD_DIV) &
                (t4_mode == `RTT_MODE_BAUD);
            RDATA_O <= 8'h00;
            // counts read live; reading while running is not exact
            if (RD_I)
            begin
                case (ADDR_I)
                    `RTT_OFF_T3_CTRL: RDATA_O <= t3_ctrl_q;
                    `RTT_OFF_T3_LOW: RDATA_O <= t3_cnt_q[7:0];
                    `RTT_OFF_T3_HIGH: RDATA_O <= t3_cnt_q[15:8];
                    `RTT_OFF_T4_CTRL: RDATA_O <= t4_ctrl_q;
                    `RTT_OFF_T4_LOW: RDATA_O <= t4_cnt_q[7:0];
                    `RTT_OFF_T4_HIGH: RDATA_O <= t4_cnt_q[15:8];
                    `RTT_OFF_MISC: RDATA_O <= {6'h00, t4_armed_q,
                        TIMER_FOUR_PIN_O};
                    default: RDATA_O <= 8'h00;
                endcase
            end
        end
    end

endmodule // rtt_reload_timers
